// *** dsc_decode_consts.vh ***
`ifndef DSC_DECODE_CONSTS_VH
`define DSC_DECODE_CONSTS_VH
// ----------------------------------------
// Instruction word layout
// ----------------------------------------
`define W_INSTR      24
`define F_OPCODE     23:16
`define F_CLASS      7:4
`define F_BASE       15:12
`define F_DMODE      11:10
`define F_DEST       9:6
`define F_SMODE      5:4
`define F_SRC        3:0
`define F_FDEST      13
`define F_FADDR      12:0
`define F_BITIND     15
`define F_BITPOS     14:11
`define F_UNSIGNED_LITERAL_TEN      13:4
`define F_LIT5       4:0
`define F_ACC        15
`define F_MULPAIR    14:13
`define F_AWB        12:11
`define F_PREF       10:0
`define F_PALO       15:1
`define F_PAHI       6:0
`define F_SHADOW     0
`define B_BYTE       0
`define B_SIGNED     1
`define B_SHORT      2
// ----------------------------------------
// Opcodes and classes
// ----------------------------------------
`define OP_NOP       8'h00
`define OP_CALLIND   8'h01
`define OP_CALL      8'h02
`define OP_JUMPIND   8'h03
`define OP_JUMP      8'h04
`define OP_RETURN    8'h06
`define OP_IRET      8'h07
`define OP_DOLOOP    8'h08
`define OP_SKIP      8'h0A
`define OP_TBLRD     8'h0B
`define OP_TBLWT     8'h0C
`define OP_DMOV      8'h0D
`define OP_MAC       8'h0E
`define OP_ACC       8'h0F
`define OP_BRA       8'h37
`define OP_BRACOND   8'h31
`define CL_THREE     4'h4
`define CL_FILE      4'h5
`define CL_BIT       4'h6
`define CL_LIT       4'h7
// ----------------------------------------
// Sizes, limits, timing
// ----------------------------------------
`define SZ_WORD      2'b00
`define SZ_BYTE      2'b01
`define SZ_DWORD     2'b10
`define AWB_IND      2'b10
`define AWB_STEP     2'h2
`define BYTE_LIT_MAX 10'h0FF
`define EXTRA_ONE    2'h1
`define EXTRA_TWO    2'h2
// ----------------------------------------
// Register map
// ----------------------------------------
`define A_CTRL       4'h0
`define A_STATUS     4'h4
`define A_LAST       4'h8
`define A_COUNT      4'hC
`define RESP_OK      2'b00
`define RESP_SLVERR  2'b10
`define ST_DSP       8
`define ST_LITERR    12
`define ST_W2ERR     13
`endif

// *** dsc_instruction_decode.v ***
// Behaviour
// - 24-bit word, 8-bit opcode plus operands
// - three opcodes take two words, 48 bits
// - second word upper eight bits zero
// - lone second word runs as no-operation
// - one cycle; taken test or PC change two; returns take three
// - branch, indirect jumps, table, returns multicycle
// - performed skip takes two or three cycles
// - double moves and two-word ops take two
// - three operands base, source, destination
// - file result to file or register zero
// - file address spans zero to 0x1FFF
// - bit position literal or from base register
// - four-bit field selects bit 0 to 15
// - literal ops base plus literal, optional dest
// - ten-bit literal 0-255 byte, 0-1023 word
// - program address literal even, LSB zero
// - ten-bit signed literal -512 to 511
// - byte, word default, double size; shadow select
// - MAC accumulator, multiplicands, prefetch, write-back
// - write-back to pointer or post-increment two
// - five arithmetic status flags kept
// - four accumulator status flags kept
`timescale 1ns/1ps
`include "dsc_decode_consts.vh"
module dsc_instruction_decode (
  input  wire        clk_sys,
  input  wire        resetn,
  input  wire        fetchValid,
  input  wire [23:0] fetchWord,
  output reg         fetchReady_q,
  input  wire        condTrue,
  input  wire [4:0]  aluFlagsIn,
  input  wire [4:0]  aluFlagsWe,
  input  wire [3:0]  dspFlagsIn,
  input  wire [3:0]  dspFlagsWe,
  output reg         decValid_q,
  output reg         decNop_q,
  output reg  [7:0]  decOpcode_q,
  output reg  [3:0]  decBase_q,
  output reg  [3:0]  decSrc_q,
  output reg  [1:0]  decSrcMode_q,
  output reg  [3:0]  decDest_q,
  output reg  [1:0]  decDestMode_q,
  output reg         decDestW0_q,
  output reg  [12:0] decFileAddr_q,
  output reg  [3:0]  decBitPos_q,
  output reg         decBitInd_q,
  output reg  [15:0] decLiteral_q,
  output reg  [22:0] decProgAddr_q,
  output reg  [1:0]  decSize_q,
  output reg         decShadow_q,
  output reg         decAcc_q,
  output reg  [1:0]  decMulPair_q,
  output reg  [10:0] decPrefetch_q,
  output reg  [1:0]  decAwb_q,
  output reg  [1:0]  decAwbStep_q,
  output reg  [4:0]  aluFlags_q,
  output reg  [3:0]  dspFlags_q,
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);
  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  localparam [2:0] S_RUN   = 3'd0;
  localparam [2:0] S_WORD2 = 3'd1;
  localparam [2:0] S_STALL = 3'd2;
  localparam [2:0] S_SKIP1 = 3'd3;
  localparam [2:0] S_SKIP2 = 3'd4;

  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg  [1:0]  stall_q;
  reg  [1:0]  stall_d;
  reg  [15:0] first_q;
  reg  [7:0]  firstOp_q;
  reg         enable_q;
  reg         litErr_q;
  reg         word2Err_q;
  reg  [31:0] count_q;
  reg         setLitErr;
  reg         setWord2Err;
  reg  [1:0]  extra;
  reg  [9:0]  unsigned_literal_ten;
  reg         byteMode;
  reg         emit;
  reg         emitNop;
  reg  [7:0]  op;

  wire        accept  = fetchValid & fetchReady_q;
  wire [7:0]  wordOp  = fetchWord[`F_OPCODE];
  wire [15:0] opnd    = fetchWord[15:0];
  wire        twoWord = (wordOp == `OP_CALL) | (wordOp == `OP_JUMP) |
                        (wordOp == `OP_DOLOOP);

  // ----------------------------------------
  // Sequencing and cycle counts
  // ----------------------------------------
  always @* begin
    state_d     = state_q;
    stall_d     = stall_q;
    emit        = 1'b0;
    emitNop     = 1'b0;
    setWord2Err = 1'b0;
    extra       = 2'h0;
    case (wordOp)
      `OP_BRA, `OP_CALLIND, `OP_JUMPIND,
      `OP_TBLRD, `OP_TBLWT, `OP_DMOV: extra = `EXTRA_ONE;
      `OP_RETURN, `OP_IRET: extra = `EXTRA_TWO;
      `OP_BRACOND: extra = condTrue ? `EXTRA_ONE : 2'h0;
      default: extra = 2'h0;
    endcase
    case (state_q)
      S_RUN: begin
        if (accept) begin
          if (twoWord) begin
            state_d = S_WORD2;
          end else begin
            emit = 1'b1;
            if (wordOp == `OP_SKIP && condTrue) begin
              state_d = S_SKIP1;
            end else if (extra != 2'h0) begin
              state_d = S_STALL;
              stall_d = extra;
            end
          end
        end
      end
      S_WORD2: begin
        if (accept) begin
          emit        = 1'b1;
          setWord2Err = (wordOp != `OP_NOP);
          state_d     = S_RUN;
        end
      end
      S_STALL: begin
        emitNop = 1'b1;
        stall_d = stall_q - 2'h1;
        if (stall_q == 2'h1) begin
          state_d = S_RUN;
        end
      end
      S_SKIP1: begin
        if (accept) begin
          emitNop = 1'b1;
          state_d = twoWord ? S_SKIP2 : S_RUN;
        end
      end
      S_SKIP2: begin
        if (accept) begin
          emitNop = 1'b1;
          state_d = S_RUN;
        end
      end
      default: state_d = S_RUN;
    endcase
  end

  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  always @* begin
    op       = (state_q == S_WORD2) ? firstOp_q : wordOp;
    byteMode = op[`B_BYTE] & ((op[`F_CLASS] == `CL_THREE) |
               (op[`F_CLASS] == `CL_FILE) | (op[`F_CLASS] == `CL_LIT));
    unsigned_literal_ten    = opnd[`F_UNSIGNED_LITERAL_TEN];
    setLitErr = emit & (op[`F_CLASS] == `CL_LIT) & ~op[`B_SHORT] &
                ~op[`B_SIGNED] & byteMode & (unsigned_literal_ten > `BYTE_LIT_MAX);
  end

  always @(posedge clk_sys) begin
    if (!resetn) begin
      state_q       <= S_RUN;
      stall_q       <= 2'h0;
      first_q       <= 16'h0000;
      firstOp_q     <= `OP_NOP;
      fetchReady_q  <= 1'b0;
      decValid_q    <= 1'b0;
      decNop_q      <= 1'b0;
      decOpcode_q   <= `OP_NOP;
      decBase_q     <= 4'h0;
      decSrc_q      <= 4'h0;
      decSrcMode_q  <= 2'h0;
      decDest_q     <= 4'h0;
      decDestMode_q <= 2'h0;
      decDestW0_q   <= 1'b0;
      decFileAddr_q <= 13'h0000;
      decBitPos_q   <= 4'h0;
      decBitInd_q   <= 1'b0;
      decLiteral_q  <= 16'h0000;
      decProgAddr_q <= 23'h00_0000;
      decSize_q     <= `SZ_WORD;
      decShadow_q   <= 1'b0;
      decAcc_q      <= 1'b0;
      decMulPair_q  <= 2'h0;
      decPrefetch_q <= 11'h000;
      decAwb_q      <= 2'h0;
      decAwbStep_q  <= 2'h0;
    end else begin
      state_q      <= state_d;
      stall_q      <= stall_d;
      // Stall drops ready so the fetcher holds the next word
      fetchReady_q <= enable_q & (state_d != S_STALL);
      if (accept && state_q == S_RUN && twoWord) begin
        first_q   <= opnd;
        firstOp_q <= wordOp;
      end
      decValid_q <= emit | emitNop;
      // Upper byte zero decodes as a no-operation
      decNop_q   <= emitNop | (emit && state_q == S_RUN && wordOp == `OP_NOP);
      decOpcode_q <= emitNop ? `OP_NOP : op;
      if (emit) begin
        decBase_q     <= opnd[`F_BASE];
        decSrc_q      <= opnd[`F_SRC];
        decSrcMode_q  <= opnd[`F_SMODE];
        decDest_q     <= opnd[`F_DEST];
        decDestMode_q <= opnd[`F_DMODE];
        decDestW0_q   <= ~opnd[`F_FDEST];
        decFileAddr_q <= opnd[`F_FADDR];
        decBitPos_q   <= opnd[`F_BITPOS];
        decBitInd_q   <= opnd[`F_BITIND];
        decShadow_q   <= opnd[`F_SHADOW] &
                         ((op == `OP_RETURN) | (op == `OP_IRET));
        decAcc_q      <= opnd[`F_ACC];
        decMulPair_q  <= opnd[`F_MULPAIR];
        decPrefetch_q <= opnd[`F_PREF];
        decAwb_q      <= opnd[`F_AWB];
        decAwbStep_q  <= (opnd[`F_AWB] == `AWB_IND) ? `AWB_STEP : 2'h0;
        if (op == `OP_DMOV) begin
          decSize_q <= `SZ_DWORD;
        end else begin
          decSize_q <= byteMode ? `SZ_BYTE : `SZ_WORD;
        end
        if (op[`F_CLASS] == `CL_LIT && op[`B_SHORT]) begin
          decLiteral_q <= {11'h000, opnd[`F_LIT5]};
        end else if (op[`F_CLASS] == `CL_LIT && op[`B_SIGNED]) begin
          decLiteral_q <= {{6{unsigned_literal_ten[9]}}, unsigned_literal_ten};
        end else if (byteMode) begin
          decLiteral_q <= {8'h00, unsigned_literal_ten[7:0]};
        end else begin
          decLiteral_q <= {6'h00, unsigned_literal_ten};
        end
        // Short literal form names its destination; long form reuses base
        if (op[`F_CLASS] == `CL_LIT && !op[`B_SHORT]) begin
          decBase_q <= opnd[`F_SRC];
          decDest_q <= opnd[`F_SRC];
        end
        if (state_q == S_WORD2) begin
          decProgAddr_q <= {opnd[`F_PAHI], first_q[`F_PALO], 1'b0};
        end
      end
    end
  end

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  reg        wrHit;
  reg [3:0]  wrAddr_q;
  reg        awHeld_q;
  reg [31:0] wData_q;
  reg [3:0]  wStrb_q;
  reg        wHeld_q;
  wire       doWrite = awHeld_q & wHeld_q & ~s_axi_bvalid;
  wire       stWr    = doWrite & (wrAddr_q == `A_STATUS) & wStrb_q[0];
  wire       stWrHi  = doWrite & (wrAddr_q == `A_STATUS) & wStrb_q[1];

  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : gAlu
      always @(posedge clk_sys) begin
        if (!resetn) begin
          aluFlags_q[g] <= 1'b0;
        end else if (aluFlagsWe[g]) begin
          aluFlags_q[g] <= aluFlagsIn[g];
        end else if (stWr) begin
          aluFlags_q[g] <= wData_q[g];
        end
      end
    end
    for (g = 0; g < 4; g = g + 1) begin : gDsp
      always @(posedge clk_sys) begin
        if (!resetn) begin
          dspFlags_q[g] <= 1'b0;
        end else if (dspFlagsWe[g]) begin
          dspFlags_q[g] <= dspFlagsIn[g];
        end else if (stWrHi) begin
          dspFlags_q[g] <= wData_q[g + `ST_DSP];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Register bus slave
  // ----------------------------------------
  always @* begin
    wrHit = (wrAddr_q == `A_CTRL) | (wrAddr_q == `A_STATUS) |
            (wrAddr_q == `A_COUNT);
  end

  always @(posedge clk_sys) begin
    if (!resetn) begin
      awHeld_q      <= 1'b0;
      wHeld_q       <= 1'b0;
      wrAddr_q      <= 4'h0;
      wData_q       <= 32'h0000_0000;
      wStrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OK;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `RESP_OK;
      s_axi_rdata   <= 32'h0000_0000;
      enable_q      <= 1'b0;
      litErr_q      <= 1'b0;
      word2Err_q    <= 1'b0;
      count_q       <= 32'h0000_0000;
    end else begin
      s_axi_awready <= ~awHeld_q & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready  <= ~wHeld_q & ~s_axi_wready & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        wrAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_q     <= 1'b0;
        wHeld_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrHit ? `RESP_OK : `RESP_SLVERR;
        if (wrAddr_q == `A_CTRL && wStrb_q[0]) begin
          enable_q <= wData_q[0];
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // Set beats a same-cycle write-one clear
      litErr_q   <= setLitErr | (litErr_q & ~(stWrHi & wData_q[`ST_LITERR]));
      word2Err_q <= setWord2Err | (word2Err_q & ~(stWrHi & wData_q[`ST_W2ERR]));
      if (doWrite && wrAddr_q == `A_COUNT && wStrb_q[0]) begin
        count_q <= 32'h0000_0000;
      end else if (emit) begin
        count_q <= count_q + 32'h0000_0001;
      end
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RESP_OK;
        case (s_axi_araddr)
          `A_CTRL:   s_axi_rdata <= {31'h0000_0000, enable_q};
          `A_STATUS: s_axi_rdata <= {16'h0000, 2'h0, word2Err_q, litErr_q,
                                     dspFlags_q, 3'h0, aluFlags_q};
          `A_LAST:   s_axi_rdata <= {13'h0000, state_q, 8'h00, decOpcode_q};
          `A_COUNT:  s_axi_rdata <= count_q;
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// *** dsc_decode_timing_monitor.sv ***
`timescale 1ns/1ps
`include "dsc_decode_consts.vh"
module dsc_decode_timing_monitor (
  input logic        clk_sys,
  input logic        resetn,
  input logic        fetchValid,
  input logic [23:0] fetchWord,
  input logic        fetchReady_q,
  input logic        condTrue,
  input logic [4:0]  aluFlagsIn,
  input logic [4:0]  aluFlagsWe,
  input logic [3:0]  dspFlagsIn,
  input logic [3:0]  dspFlagsWe,
  input logic        decValid_q,
  input logic        decNop_q,
  input logic [7:0]  decOpcode_q,
  input logic        decDestW0_q,
  input logic [12:0] decFileAddr_q,
  input logic [15:0] decLiteral_q,
  input logic [22:0] decProgAddr_q,
  input logic [4:0]  aluFlags_q,
  input logic [3:0]  dspFlags_q
);
  // ------
  // Helpers
  // ------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic [7:0] op;
  logic       take;
  assign op   = fetchWord[23:16];
  assign take = fetchValid && fetchReady_q;
  // ------
  // Properties
  // ------
  property p_bra;
    take && op == `OP_BRA |=> decValid_q && !decNop_q && decOpcode_q == `OP_BRA
      ##1 decValid_q && decNop_q;
  endproperty
  a_bra: assert property (p_bra)
    else $error("branch nop cycle missing");
  property p_stall;
    decValid_q && !decNop_q && decOpcode_q == `OP_BRA
      |-> !fetchReady_q ##1 (decValid_q && decNop_q && fetchReady_q);
  endproperty
  a_stall: assert property (p_stall)
    else $error("fetch not held during branch");
  property p_ret;
    take && (op == `OP_RETURN || op == `OP_IRET) |=> decValid_q && !decNop_q
      ##1 (decValid_q && decNop_q) [*2];
  endproperty
  a_ret: assert property (p_ret)
    else $error("return not three cycles");
  property p_dmov;
    take && op == `OP_DMOV |=> decValid_q && !decNop_q
      ##1 (decValid_q && decNop_q && fetchReady_q);
  endproperty
  a_dmov: assert property (p_dmov)
    else $error("double move not two cycles");
  property p_file;
    take && op[7:4] == `CL_FILE |=> decFileAddr_q == $past(fetchWord[12:0])
      && decDestW0_q == !$past(fetchWord[13]);
  endproperty
  a_file: assert property (p_file)
    else $error("file operand decode wrong");
  property p_slit;
    take && op[7:4] == `CL_LIT && op[2:0] == 3'b010
      |=> decLiteral_q == {{6{$past(fetchWord[13])}}, $past(fetchWord[13:4])};
  endproperty
  a_slit: assert property (p_slit)
    else $error("signed literal not extended");
  property p_blit;
    take && op[7:4] == `CL_LIT && op[2:0] == 3'b001
      |=> decLiteral_q == {8'h00, $past(fetchWord[11:4])};
  endproperty
  a_blit: assert property (p_blit)
    else $error("byte literal not limited");
  property p_even;
    decValid_q && !decNop_q |-> decProgAddr_q[0] == 1'b0;
  endproperty
  a_even: assert property (p_even)
    else $error("program address odd");
  property p_alu;
    |aluFlagsWe |=> ((aluFlags_q ^ $past(aluFlagsIn)) & $past(aluFlagsWe)) == 5'h00;
  endproperty
  a_alu: assert property (p_alu)
    else $error("arithmetic flag not updated");
  property p_dsp;
    |dspFlagsWe |=> ((dspFlags_q ^ $past(dspFlagsIn)) & $past(dspFlagsWe)) == 4'h0;
  endproperty
  a_dsp: assert property (p_dsp)
    else $error("accumulator flag not updated");
  c_skip: cover property (take && op == `OP_SKIP && condTrue ##1 decValid_q ##1 decNop_q);
  c_two: cover property (take && op == `OP_JUMP);
  c_nops: cover property (decValid_q && decNop_q [*2]);
endmodule
bind dsc_instruction_decode dsc_decode_timing_monitor mon (
  .clk_sys(clk_sys), .resetn(resetn), .fetchValid(fetchValid), .fetchWord(fetchWord),
  .fetchReady_q(fetchReady_q), .condTrue(condTrue), .aluFlagsIn(aluFlagsIn),
  .aluFlagsWe(aluFlagsWe), .dspFlagsIn(dspFlagsIn), .dspFlagsWe(dspFlagsWe),
  .decValid_q(decValid_q), .decNop_q(decNop_q), .decOpcode_q(decOpcode_q),
  .decDestW0_q(decDestW0_q), .decFileAddr_q(decFileAddr_q), .decLiteral_q(decLiteral_q),
  .decProgAddr_q(decProgAddr_q), .aluFlags_q(aluFlags_q), .dspFlags_q(dspFlags_q)
);

// *** dsc_instruction_decode_timing_tb.sv ***
`timescale 1ns/1ps
`include "dsc_decode_consts.vh"
module dsc_instruction_decode_timing_tb;
  typedef struct {
    logic        n;
    logic [7:0]  o;
    logic [1:0]  s;
    logic [23:0] v;
  } exp_t;
  logic        clk_sys, resetn, fetchValid, condTrue, fetchReady_q, decValid_q, decNop_q;
  logic        decDestW0_q, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready;
  logic [23:0] fetchWord;
  logic [4:0]  aluFlagsIn, aluFlagsWe;
  logic [3:0]  dspFlagsIn, dspFlagsWe, s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [7:0]  decOpcode_q;
  logic [12:0] decFileAddr_q;
  logic [15:0] decLiteral_q;
  logic [22:0] decProgAddr_q;
  logic [31:0] s_axi_wdata, s_axi_rdata, r;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [8:0]  st;
  logic [9:0]  lits [3];
  logic [7:0]  ops [14];
  int          error_cnt, compares, cyc, nReal;
  exp_t        e;
  exp_t        decQ[$];
  logic [33:0] rdQ[$];
  dsc_instruction_decode uut (
    .clk_sys, .resetn, .fetchValid, .fetchWord, .fetchReady_q, .condTrue, .aluFlagsIn,
    .aluFlagsWe, .dspFlagsIn, .dspFlagsWe, .decValid_q, .decNop_q, .decOpcode_q,
    .decBase_q(), .decSrc_q(), .decSrcMode_q(), .decDest_q(), .decDestMode_q(),
    .decDestW0_q, .decFileAddr_q, .decBitPos_q(), .decBitInd_q(), .decLiteral_q,
    .decProgAddr_q, .decSize_q(), .decShadow_q(), .decAcc_q(), .decMulPair_q(),
    .decPrefetch_q(), .decAwb_q(), .decAwbStep_q(), .aluFlags_q(), .dspFlags_q(),
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready
  );
  // ------
  // Tasks
  // ------
  task chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task final_report;
    if (error_cnt == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  function int xtra(input [7:0] o, input c);
    case (o)
      `OP_BRA, `OP_CALLIND, `OP_JUMPIND, `OP_TBLRD, `OP_TBLWT, `OP_DMOV: xtra = 1;
      `OP_RETURN, `OP_IRET: xtra = 2;
      `OP_BRACOND: xtra = c;
      default: xtra = 0;
    endcase
  endfunction
  task push(input logic n, input [7:0] o, input [1:0] s, input [23:0] v);
    decQ.push_back('{n, o, s, v});
    if (!n) nReal++;
  endtask
  // Word stays offered until the decoder samples ready high
  task fw(input [23:0] w, input c);
    fetchValid <= 1'b1;
    fetchWord  <= w;
    condTrue   <= c;
    do begin
      @(posedge clk_sys);
    end while (fetchReady_q !== 1'b1);
  endtask
  task op1(input [7:0] o, input c, input [1:0] s, input [23:0] v, input [15:0] lo);
    push(o == 8'h00, o, s, v);
    // A lone no-operation word is still counted as a decode
    if (o == 8'h00) nReal++;
    repeat (xtra(o, c)) push(1'b1, 8'h00, 2'd0, 24'h0);
    fw({o, lo}, c);
  endtask
  task op2(input [7:0] o, input [7:0] hi, input skipped);
    logic [15:0] a;
    logic [15:0] b;
    {a, b} = $urandom;
    if (skipped) begin
      push(1'b1, 8'h00, 2'd0, 24'h0);
      push(1'b1, 8'h00, 2'd0, 24'h0);
    end else begin
      push(1'b0, o, (hi == 8'h00) ? 2'd2 : 2'd0, {1'b0, b[6:0], a[15:1], 1'b0});
    end
    fw({o, a}, 1'b0);
    fw({hi, b}, 1'b0);
  endtask
  task axw(input [3:0] a, input [31:0] d);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    @(posedge clk_sys);
  endtask
  task axr(input [3:0] a, input [33:0] x);
    rdQ.push_back(x);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    @(posedge clk_sys);
  endtask
  // ------
  // Clock and checkers
  // ------
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      chk("rdata", {s_axi_rresp, s_axi_rdata}, rdQ.pop_front());
    end
  end
  always @(posedge clk_sys) begin
    if (resetn === 1'b1 && decValid_q === 1'b1) begin
      if (decQ.size() == 0) chk("extra decode", 1, 0);
      else begin
        e = decQ.pop_front();
        chk("decode", {decNop_q, decOpcode_q}, {e.n, e.o});
        if (e.s == 2'd1) chk("literal", decLiteral_q, e.v);
        if (e.s == 2'd2) chk("prog addr", decProgAddr_q, e.v);
        if (e.s == 2'd3) chk("file", {decDestW0_q, decFileAddr_q}, e.v);
      end
    end
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      final_report;
    end
  end
  // ------
  // Sequence
  // ------
  initial begin
    {resetn, fetchValid, condTrue, fetchWord, aluFlagsIn, aluFlagsWe} = '0;
    {dspFlagsIn, dspFlagsWe, s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, st} = '0;
    ops = '{8'h40, `OP_BRA, `OP_CALLIND, `OP_JUMPIND, `OP_TBLRD, `OP_TBLWT, `OP_DMOV,
            `OP_RETURN, `OP_IRET, `OP_BRACOND, `OP_NOP, `OP_ACC, `OP_MAC, 8'h60};
    r = $urandom(6);
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    axr(`A_CTRL, 34'h0);
    axr(`A_STATUS, 34'h0);
    axr(`A_COUNT, 34'h0);
    axr(4'h2, {`RESP_SLVERR, 32'h0000_0000});
    axw(`A_CTRL, 32'h0000_0001);
    for (int c = 0; c < 2; c++) foreach (ops[i]) begin
      r = $urandom;
      op1(ops[i], c[0], 2'd0, 24'h0, r[15:0]);
    end
    op2(`OP_CALL, 8'h00, 1'b0);
    op2(`OP_JUMP, 8'h00, 1'b0);
    op2(`OP_DOLOOP, 8'h00, 1'b0);
    for (int c = 0; c < 2; c++) begin
      r = $urandom;
      op1(`OP_SKIP, c[0], 2'd0, 24'h0, r[15:0]);
      push(c[0], c[0] ? 8'h00 : 8'h40, 2'd0, 24'h0);
      fw({8'h40, r[31:16]}, 1'b0);
      op1(`OP_SKIP, c[0], 2'd0, 24'h0, r[15:0]);
      op2(`OP_JUMP, 8'h00, c[0]);
    end
    r = $urandom;
    lits = '{10'h200, 10'h1FF, r[9:0]};
    foreach (lits[i]) op1(8'h72, 1'b0, 2'd1, {8'h00, {6{lits[i][9]}}, lits[i]},
                          {2'b00, lits[i], 4'h3});
    op1(8'h70, 1'b0, 2'd1, {14'h0, 10'h3FF}, {2'b00, 10'h3FF, 4'h1});
    op1(8'h71, 1'b0, 2'd1, {16'h0, r[7:0]}, {4'h0, r[7:0], 4'h1});
    op1(8'h71, 1'b0, 2'd1, {16'h0, r[7:0]}, {4'h1, r[7:0], 4'h1});
    op1(8'h50, 1'b0, 2'd3, {11'h1, 13'h1FFF}, {3'b000, 13'h1FFF});
    op1(8'h51, 1'b0, 2'd3, {11'h0, r[22:10]}, {3'b011, r[22:10]});
    op1(8'h74, 1'b0, 2'd1, {19'h0, r[4:0]}, {11'h000, r[4:0]});
    op2(`OP_JUMP, 8'hA5, 1'b0);
    fetchValid <= 1'b0;
    axr(`A_STATUS, 34'h0_0000_3000);
    axw(`A_STATUS, 32'h0000_3000);
    axr(`A_STATUS, 34'h0);
    // First pass forces every enable so the model starts from known flags
    for (int i = 0; i < 4; i++) begin
      r = $urandom | (i == 0 ? 32'h0003_C3E0 : 32'h0);
      aluFlagsIn <= r[4:0];
      aluFlagsWe <= r[9:5];
      dspFlagsIn <= r[13:10];
      dspFlagsWe <= r[17:14];
      st[4:0] = (st[4:0] & ~r[9:5]) | (r[4:0] & r[9:5]);
      st[8:5] = (st[8:5] & ~r[17:14]) | (r[13:10] & r[17:14]);
      @(posedge clk_sys);
      aluFlagsWe <= 5'h00;
      dspFlagsWe <= 4'h0;
      axr(`A_STATUS, {22'h0, st[8:5], 3'b000, st[4:0]});
    end
    axr(`A_COUNT, {2'b00, nReal});
    axw(`A_COUNT, 32'h0000_0001);
    axr(`A_COUNT, 34'h0);
    repeat (4) @(posedge clk_sys);
    chk("pending", decQ.size() + rdQ.size(), 0);
    final_report;
  end
endmodule
